// file: include/tester_status_pkg.sv
package tester_status_pkg;
  localparam int unsigned WORD_W            = 16;
  localparam int unsigned VAL_W             = 16;
  localparam int unsigned PCT_W             = 8;
  localparam int unsigned PULSE_W           = 24;
  localparam int unsigned NUM_FAULT         = 5;
  localparam int unsigned NUM_GP            = 4;
  localparam int unsigned ADDR_W            = 6;
  // Word addresses on the fieldbus map
  localparam logic [ADDR_W-1:0] ADDR_FAULT_RESET_CMD = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_A        = 6'h0F;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_B        = 6'h10;
  // Status word A bit positions
  localparam int unsigned A_HV_ENABLED      = 0;
  localparam int unsigned A_HV_LEVEL        = 1;
  localparam int unsigned A_WINDOW          = 2;
  localparam int unsigned A_FAULT_PULSE     = 3;
  localparam int unsigned A_ALARM_LSB       = 4;
  localparam int unsigned A_LIMIT_LSB       = 9;
  localparam int unsigned A_COMBO_LIMIT     = 14;
  localparam int unsigned A_ACTUAL_TOL      = 15;
  // Status word B bit positions
  localparam int unsigned B_ELECTRODE_TOL   = 0;
  localparam int unsigned B_BARE_WIRE       = 1;
  localparam int unsigned B_PINHOLE_B       = 2;
  localparam int unsigned B_COVER_CLOSED    = 3;
  localparam int unsigned B_LOAD_LIMIT      = 4;
  localparam int unsigned B_GP_OUT_LSB      = 8;
  localparam int unsigned B_GP_IN_LSB       = 12;
  localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [31:0]       PCT_FULL     = 32'h0000_0064;
endpackage

// file: hw/tester_status_flag_words.sv
`timescale 1ns/1ps
// Contract
// RL1 - Bit 0 A: all high-voltage permissives met
// RL2 - Bit 1 A: actual voltage at/above on-threshold
// RL3 - Bit 2 A: voltage inside window limits
// RL4 - Bit 3 A: fault pulse, self-clearing after duration
// RL5 - Bits 4-8 A: latched alarms until fault reset
// RL6 - Bits 9-13: count limits latched until count reset
// RL7 - Bit 14 A: combined count limit, latched
// RL8 - Bit 15 A: actual voltage within setpoint tolerance
// RL9 - Bit 0 B: electrode voltage within setpoint tolerance
// RL10 - Bits 1-2 B: latched alarms until fault reset
// RL11 - Bit 3 B: one when cover closed
// RL12 - Bit 4 B: load at/above load limit
// RL13 - Bits 8-11 B: general output states
// RL14 - Bits 12-15 B: general input states
// RL15 - Word as two bytes, low byte first
// RL16 - Fault reset command change clears alarms
// RL17 - Commands act on value change only
// RL18 - Bits 5-7 B always read zero
// RL19 - Words refresh each clock; coherent read snapshot
module tester_status_flag_words #(
  parameter int unsigned VAL_W   = tester_status_pkg::VAL_W,
  parameter int unsigned PULSE_W = tester_status_pkg::PULSE_W
) (
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rst_i,
  input  wire logic                                   hv_permit_i,
  input  wire logic [VAL_W-1:0]                       actual_voltage_i,
  input  wire logic [VAL_W-1:0]                       electrode_voltage_i,
  input  wire logic [VAL_W-1:0]                       setpoint_i,
  input  wire logic [VAL_W-1:0]                       high_voltage_level_i,
  input  wire logic [VAL_W-1:0]                       voltage_window_low_i,
  input  wire logic [VAL_W-1:0]                       voltage_window_high_i,
  input  wire logic [tester_status_pkg::PCT_W-1:0]    actual_setpoint_tolerance_i,
  input  wire logic [tester_status_pkg::PCT_W-1:0]    electrode_setpoint_tolerance_i,
  input  wire logic [tester_status_pkg::PCT_W-1:0]    load_pct_i,
  input  wire logic [tester_status_pkg::PCT_W-1:0]    load_limit_i,
  input  wire logic [PULSE_W-1:0]                     fault_pulse_cycles_i,
  input  wire logic [tester_status_pkg::NUM_FAULT-1:0] fault_detect_i,
  input  wire logic [VAL_W*tester_status_pkg::NUM_FAULT-1:0] fault_count_i,
  input  wire logic [VAL_W*tester_status_pkg::NUM_FAULT-1:0] fault_limit_i,
  input  wire logic [VAL_W-1:0]                       combo_count_i,
  input  wire logic [VAL_W-1:0]                       combo_limit_i,
  input  wire logic                                   fault_count_reset_i,
  input  wire logic                                   bare_wire_alarm_i,
  input  wire logic                                   pinhole_alarm_b_i,
  input  wire logic                                   cover_closed_i,
  input  wire logic [tester_status_pkg::NUM_GP-1:0]   general_output_i,
  input  wire logic [tester_status_pkg::NUM_GP-1:0]   general_input_i,
  input  wire logic                                   wr_en_i,
  input  wire logic [tester_status_pkg::ADDR_W-1:0]   wr_addr_i,
  input  wire logic [tester_status_pkg::WORD_W-1:0]   wr_data_i,
  input  wire logic                                   rd_en_i,
  input  wire logic [tester_status_pkg::ADDR_W:0]     rd_byte_addr_i,
  output logic      [7:0]                             rd_data_o,
  output logic                                        rd_valid_o,
  output logic      [tester_status_pkg::WORD_W-1:0]   status_a_o,
  output logic      [tester_status_pkg::WORD_W-1:0]   status_b_o
);
  import tester_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Tolerance band: |v - sp| * 100 <= pct * sp, kept wide to avoid overflow
  function automatic logic within_pct(input logic [VAL_W-1:0] v,
                                      input logic [VAL_W-1:0] sp,
                                      input logic [PCT_W-1:0] pct);
    logic [VAL_W-1:0] diff;
    logic [47:0]      lhs;
    logic [47:0]      rhs;
    diff = (v >= sp) ? v - sp : sp - v;
    lhs  = 48'(diff) * 48'(PCT_FULL);
    rhs  = 48'(pct) * 48'(sp);
    return lhs <= rhs;
  endfunction

  // Sticky flag: set wins so an event in the clear cycle is kept
  function automatic logic hold_flag(input logic held,
                                     input logic hit,
                                     input logic clear);
    return (held & ~clear) | hit;
  endfunction

  // One slice of a packed group of per-fault values
  function automatic logic [VAL_W-1:0] slice_of(input logic [VAL_W*NUM_FAULT-1:0] bus,
                                                input int unsigned              idx);
    return bus[idx*VAL_W +: VAL_W];
  endfunction

  // At-or-above test shared by thresholds and limits
  function automatic logic reached(input logic [VAL_W-1:0] value,
                                   input logic [VAL_W-1:0] limit);
    return value >= limit;
  endfunction

  // Byte lane of a word; the low lane sits at the even byte address
  function automatic logic [7:0] byte_of(input logic [WORD_W-1:0] full,
                                         input logic              high);
    return high ? full[WORD_W-1 -: 8] : full[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [WORD_W-1:0]    last_reset_cmd;
  logic [WORD_W-1:0]    next_last_reset_cmd;
  logic [NUM_FAULT-1:0] alarm;
  logic [NUM_FAULT-1:0] next_alarm;
  logic [NUM_FAULT-1:0] limit_hit;
  logic [NUM_FAULT-1:0] next_limit_hit;
  logic                 combo_hit;
  logic                 next_combo_hit;
  logic                 bare_wire;
  logic                 next_bare_wire;
  logic                 pinhole_b;
  logic                 next_pinhole_b;
  logic [PULSE_W-1:0]   pulse_cnt;
  logic [PULSE_W-1:0]   next_pulse_cnt;
  logic [WORD_W-1:0]    next_status_a;
  logic [WORD_W-1:0]    next_status_b;
  logic                 fault_reset;

  ////////////////////////////////////////////////////////////////////////////
  // A repeated write of the same value does nothing
  // Stored value resets to zero, so a first command of zero is ignored
  assign fault_reset = wr_en_i && (wr_addr_i == ADDR_FAULT_RESET_CMD)
                       && (wr_data_i != last_reset_cmd); // RL16 RL17

  always_comb begin
    next_last_reset_cmd = last_reset_cmd;
    if (wr_en_i && (wr_addr_i == ADDR_FAULT_RESET_CMD)) begin
      next_last_reset_cmd = wr_data_i; // RL17
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      last_reset_cmd <= '0;
    end else begin
      last_reset_cmd <= next_last_reset_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word A alarms; set wins so a fault arriving with the reset is kept
  always_comb begin
    next_alarm = alarm;
    for (int unsigned i = 0; i < NUM_FAULT; i++) begin
      next_alarm[i] = hold_flag(alarm[i], fault_detect_i[i], fault_reset); // RL5 RL16
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      alarm <= '0;
    end else begin
      alarm <= next_alarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word B alarms share the same single reset command
  always_comb begin
    next_bare_wire = hold_flag(bare_wire, bare_wire_alarm_i, fault_reset); // RL10 RL16
    next_pinhole_b = hold_flag(pinhole_b, pinhole_alarm_b_i, fault_reset); // RL10 RL16
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bare_wire <= 1'b0;
      pinhole_b <= 1'b0;
    end else begin
      bare_wire <= next_bare_wire;
      pinhole_b <= next_pinhole_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit latches keep setting while a count stays high, even across a reset
  // Unsigned compares, so a zero limit always reads as reached
  always_comb begin
    next_limit_hit = limit_hit;
    for (int unsigned i = 0; i < NUM_FAULT; i++) begin
      next_limit_hit[i] = hold_flag(limit_hit[i],
                                    reached(slice_of(fault_count_i, i),
                                            slice_of(fault_limit_i, i)),
                                    fault_count_reset_i); // RL6
    end
    next_combo_hit = hold_flag(combo_hit, reached(combo_count_i, combo_limit_i),
                               fault_count_reset_i); // RL7
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      limit_hit <= '0;
      combo_hit <= 1'b0;
    end else begin
      limit_hit <= next_limit_hit;
      combo_hit <= next_combo_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retrigger restarts the pulse length; zero length gives no pulse
  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (|fault_detect_i) begin
      next_pulse_cnt = fault_pulse_cycles_i; // RL4
    end else if (pulse_cnt != '0) begin
      next_pulse_cnt = pulse_cnt - PULSE_W'(1); // RL4
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pulse_cnt <= '0;
    end else begin
      pulse_cnt <= next_pulse_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status words built from next state so they track sources every cycle
  always_comb begin
    next_status_a = STATUS_RESET;
    next_status_a[A_HV_ENABLED]  = hv_permit_i; // RL1
    next_status_a[A_HV_LEVEL]    = reached(actual_voltage_i, high_voltage_level_i); // RL2
    next_status_a[A_WINDOW]      = (actual_voltage_i >= voltage_window_low_i)
                                   && (actual_voltage_i <= voltage_window_high_i); // RL3
    next_status_a[A_FAULT_PULSE] = next_pulse_cnt != '0; // RL4
    next_status_a[A_ALARM_LSB +: NUM_FAULT] = next_alarm; // RL5
    next_status_a[A_LIMIT_LSB +: NUM_FAULT] = next_limit_hit; // RL6
    next_status_a[A_COMBO_LIMIT] = next_combo_hit; // RL7
    next_status_a[A_ACTUAL_TOL]  = within_pct(actual_voltage_i, setpoint_i,
                                              actual_setpoint_tolerance_i); // RL8
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_a_o <= STATUS_RESET;
    end else begin
      status_a_o <= next_status_a; // RL19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlisted bits 5..7 stay at reset zero
  always_comb begin
    next_status_b = STATUS_RESET; // RL18
    next_status_b[B_ELECTRODE_TOL] = within_pct(electrode_voltage_i, setpoint_i,
                                                electrode_setpoint_tolerance_i); // RL9
    next_status_b[B_BARE_WIRE]     = next_bare_wire; // RL10
    next_status_b[B_PINHOLE_B]     = next_pinhole_b; // RL10
    next_status_b[B_COVER_CLOSED]  = cover_closed_i; // RL11
    next_status_b[B_LOAD_LIMIT]    = load_pct_i >= load_limit_i; // RL12
    next_status_b[B_GP_OUT_LSB +: NUM_GP] = general_output_i; // RL13
    next_status_b[B_GP_IN_LSB +: NUM_GP]  = general_input_i; // RL14
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_b_o <= STATUS_RESET;
    end else begin
      status_b_o <= next_status_b; // RL19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte read: low byte read freezes whole word so the high byte matches
  logic [WORD_W-1:0] snap;
  logic [WORD_W-1:0] next_snap;
  logic [7:0]        next_rd_data;
  logic [ADDR_W-1:0] rd_word;
  logic              rd_high;

  assign rd_word = rd_byte_addr_i[ADDR_W:1];
  assign rd_high = rd_byte_addr_i[0];

  always_comb begin
    next_snap    = snap;
    next_rd_data = 8'h00;
    if (rd_en_i && !rd_high) begin
      if (rd_word == ADDR_STATUS_A) begin
        next_snap = status_a_o; // RL19
      end else if (rd_word == ADDR_STATUS_B) begin
        next_snap = status_b_o; // RL19
      end else begin
        next_snap = STATUS_RESET;
      end
      next_rd_data = byte_of(next_snap, 1'b0); // RL15
    end else if (rd_en_i) begin
      next_rd_data = byte_of(snap, 1'b1); // RL15
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      snap       <= STATUS_RESET;
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      snap       <= next_snap;
      rd_data_o  <= next_rd_data;
      rd_valid_o <= rd_en_i;
    end
  end
endmodule

// file: testbench/fieldbus_master_model.sv
`timescale 1ns/1ps
module fieldbus_master_model (
  input  wire logic        sys_clk_i,
  input  wire logic [7:0]  rd_data_i,
  input  wire logic        rd_valid_i,
  output logic             wr_en_o,
  output logic      [5:0]  wr_addr_o,
  output logic      [15:0] wr_data_o,
  output logic             rd_en_o,
  output logic      [6:0]  rd_addr_o
);
  initial begin
    {wr_en_o, rd_en_o, wr_addr_o, wr_data_o, rd_addr_o} = '0;
  end
  ////////////////////////////////////////
  // Caller must change the value to repeat a command
  task automatic write_word(input logic [5:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    {wr_en_o, wr_addr_o, wr_data_o} = {1'b1, a, d};
    @(negedge sys_clk_i);
    {wr_en_o, wr_addr_o, wr_data_o} = {1'b0, ~a, ~d};
  endtask
  // Low byte first, so the high byte comes from the same snapshot
  task automatic read_word(input logic [6:0] a, output logic [15:0] w);
    for (int i = 0; i < 2; i++) begin
      @(negedge sys_clk_i);
      {rd_en_o, rd_addr_o} = {1'b1, a + 7'(i)};
      @(negedge sys_clk_i);
      {rd_en_o, rd_addr_o} = {1'b0, ~rd_addr_o};
      w[i*8+:8] = rd_valid_i ? rd_data_i : 8'hXX;
    end
  endtask
endmodule

// file: testbench/tester_status_flag_words_monitor.sv
`timescale 1ns/1ps
module tester_status_monitor (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        hv_permit_i,
  input wire logic [15:0] actual_voltage_i,
  input wire logic [15:0] high_voltage_level_i,
  input wire logic [7:0]  load_pct_i,
  input wire logic [7:0]  load_limit_i,
  input wire logic        cover_closed_i,
  input wire logic [3:0]  general_output_i,
  input wire logic [3:0]  general_input_i,
  input wire logic [4:0]  fault_detect_i,
  input wire logic        rd_en_i,
  input wire logic        rd_valid_o,
  input wire logic [15:0] status_a_o,
  input wire logic [15:0] status_b_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_hv_enable_bit: assert property (!$past(rst_i) |-> status_a_o[0] == $past(hv_permit_i))
    else $error("hv enable bit wrong");
  a_hv_level: assert property (!$past(rst_i) |-> status_a_o[1] ==
    ($past(actual_voltage_i) >= $past(high_voltage_level_i))) else $error("level bit wrong");
  a_alarm_set: assert property (|fault_detect_i |=>
    (status_a_o[8:4] & $past(fault_detect_i)) == $past(fault_detect_i)) else $error("alarm lost");
  a_cover_bit: assert property (!$past(rst_i) |-> status_b_o[3] == $past(cover_closed_i))
    else $error("cover bit wrong");
  a_load_limit: assert property (!$past(rst_i) |-> status_b_o[4] ==
    ($past(load_pct_i) >= $past(load_limit_i))) else $error("load bit wrong");
  a_gp_mirror: assert property (!$past(rst_i) |-> status_b_o[15:8] ==
    {$past(general_input_i), $past(general_output_i)}) else $error("gp bits wrong");
  a_spare_zero: assert property (status_b_o[7:5] == 3'h0) else $error("spare bits set");
  a_read_valid: assert property (!$past(rst_i) |-> rd_valid_o == $past(rd_en_i))
    else $error("read valid wrong");
endmodule
bind tester_status_flag_words tester_status_monitor i_monitor (.sys_clk_i, .rst_i, .hv_permit_i,
  .actual_voltage_i, .high_voltage_level_i, .load_pct_i, .load_limit_i, .cover_closed_i,
  .general_output_i, .general_input_i, .fault_detect_i, .rd_en_i, .rd_valid_o, .status_a_o,
  .status_b_o);

// file: testbench/tester_status_flag_words_test.sv
`timescale 1ns/1ps
module tester_status_flag_words_test;
  import tester_status_pkg::*;
  logic        sys_clk_i, rst_i, hv_permit_i, fault_count_reset_i, cover_closed_i;
  logic        bare_wire_alarm_i, pinhole_alarm_b_i, wr_en_i, rd_en_i, rd_valid_o;
  logic [15:0] actual_voltage_i, electrode_voltage_i, setpoint_i, high_voltage_level_i;
  logic [15:0] voltage_window_low_i, voltage_window_high_i, combo_count_i, combo_limit_i;
  logic [15:0] wr_data_i, status_a_o, status_b_o, w;
  logic [7:0]  actual_setpoint_tolerance_i, electrode_setpoint_tolerance_i;
  logic [7:0]  load_pct_i, load_limit_i, rd_data_o;
  logic [23:0] fault_pulse_cycles_i;
  logic [79:0] fault_count_i, fault_limit_i;
  logic [6:0]  rd_byte_addr_i;
  logic [5:0]  wr_addr_i;
  logic [4:0]  fault_detect_i;
  logic [3:0]  general_output_i, general_input_i;
  int          bad_count, n_checks;
  tester_status_flag_words i_dut (.sys_clk_i, .rst_i, .hv_permit_i, .actual_voltage_i,
    .electrode_voltage_i, .setpoint_i, .high_voltage_level_i, .voltage_window_low_i,
    .voltage_window_high_i, .actual_setpoint_tolerance_i, .electrode_setpoint_tolerance_i,
    .load_pct_i, .load_limit_i, .fault_pulse_cycles_i, .fault_detect_i, .fault_count_i,
    .fault_limit_i, .combo_count_i, .combo_limit_i, .fault_count_reset_i, .bare_wire_alarm_i,
    .pinhole_alarm_b_i, .cover_closed_i, .general_output_i, .general_input_i, .wr_en_i,
    .wr_addr_i, .wr_data_i, .rd_en_i, .rd_byte_addr_i, .rd_data_o, .rd_valid_o, .status_a_o,
    .status_b_o);
  fieldbus_master_model i_master (.sys_clk_i, .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i), .rd_en_o(rd_en_i),
    .rd_addr_o(rd_byte_addr_i));
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic apply(logic hp, logic [15:0] av, ev, logic [7:0] ld, logic cv, logic [3:0] g);
    {hv_permit_i, actual_voltage_i, electrode_voltage_i, load_pct_i} = {hp, av, ev, ld};
    {cover_closed_i, general_output_i, general_input_i} = {cv, g, ~g};
  endtask
  ////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // Run needs well under a thousand cycles
  initial begin
    #50000;
    bad_count++;
    give_verdict();
  end
  initial begin
    rst_i = 1'b1;
    {fault_count_reset_i, bare_wire_alarm_i, pinhole_alarm_b_i, fault_detect_i} = '0;
    {fault_count_i, combo_count_i, fault_pulse_cycles_i} = {96'h0, 24'h000003};
    {setpoint_i, high_voltage_level_i, voltage_window_low_i} = {16'h03E8, 16'h044C, 16'h044C};
    {voltage_window_high_i, combo_limit_i, fault_limit_i} = {16'h07D0, 16'h0005, {5{16'h0005}}};
    {actual_setpoint_tolerance_i, electrode_setpoint_tolerance_i, load_limit_i} = 24'h0A0A32;
    apply(1'b1, 16'h044C, 16'h0384, 8'h32, 1'b1, 4'h5);
    tick(10);
    check("reset_a", status_a_o, 16'h0000);
    rst_i = 1'b0;
    tick(2);
    check("word_a", status_a_o, 16'h8007);
    check("word_b", status_b_o, 16'hA519);
    i_master.read_word(7'h1E, w);
    check("read_a", w, 16'h8007);
    i_master.read_word(7'h20, w);
    check("read_b", w, 16'hA519);
    i_master.read_word(7'h00, w);
    check("read_unmapped", w, 16'h0000);
    // Just outside both tolerances and the load limit, then just below the window
    apply(1'b0, 16'h044D, 16'h0383, 8'h31, 1'b0, 4'hA);
    tick(1);
    check("edge_a", status_a_o, 16'h0006);
    check("edge_b", status_b_o, 16'h5A00);
    apply(1'b1, 16'h044B, 16'h0384, 8'h32, 1'b1, 4'h5);
    tick(1);
    check("below_a", status_a_o, 16'h8001);
    apply(1'b1, 16'h044C, 16'h0384, 8'h32, 1'b1, 4'h5);
    {fault_detect_i, bare_wire_alarm_i, pinhole_alarm_b_i} = 7'h7F;
    tick(1);
    {fault_detect_i, bare_wire_alarm_i, pinhole_alarm_b_i} = 7'h00;
    check("alarm_a", status_a_o, 16'h81FF);
    check("alarm_b", status_b_o, 16'hA51F);
    tick(2);
    check("pulse_hold", status_a_o, 16'h81FF);
    tick(1);
    check("pulse_end", status_a_o, 16'h81F7);
    // Other address and an unchanged command value leave alarms set
    i_master.write_word(6'h02, 16'h0001);
    i_master.write_word(ADDR_FAULT_RESET_CMD, 16'h0000);
    check("no_clear", status_a_o & 16'h01F0, 16'h01F0);
    i_master.write_word(ADDR_FAULT_RESET_CMD, 16'h0001);
    check("cleared_a", status_a_o, 16'h8007);
    check("cleared_b", status_b_o, 16'hA519);
    fault_detect_i = 5'h02;
    tick(1);
    fault_detect_i = 5'h00;
    i_master.write_word(ADDR_FAULT_RESET_CMD, 16'h0001);
    check("repeat_cmd", status_a_o & 16'h01F0, 16'h0020);
    i_master.write_word(ADDR_FAULT_RESET_CMD, 16'h0000);
    check("toggle_cmd", status_a_o & 16'h01F0, 16'h0000);
    {fault_count_i, combo_count_i} = {{5{16'h0004}}, 16'h0004};
    tick(1);
    check("under_limit", status_a_o & 16'h7E00, 16'h0000);
    {fault_count_i, combo_count_i} = {{5{16'h0005}}, 16'h0005};
    tick(1);
    {fault_count_i, combo_count_i} = '0;
    tick(1);
    check("limit_held", status_a_o & 16'h7E00, 16'h7E00);
    fault_count_reset_i = 1'b1;
    tick(1);
    fault_count_reset_i = 1'b0;
    check("limit_clear", status_a_o & 16'h7E00, 16'h0000);
    fault_count_i = {16'h0000, 16'h0005, 48'h0000_0000_0000};
    tick(1);
    check("limit_slice", status_a_o & 16'h7E00, 16'h1000);
    give_verdict();
  end
endmodule
